// [drive_pkg.sv]
// shared constants and types for the drive state machine and its host
package drive_pkg;

	typedef enum logic [2:0] {
		ST_INIT,
		ST_NO_FAULT,
		ST_READY,
		ST_WAIT_ON,
		ST_RUNNING,
		ST_QUICK_STOP,
		ST_STOP_FAULT,
		ST_FAULT
	} drive_state_type;

	// host control words
	localparam logic [15:0] CW_DISABLE     = 16'h0000;
	localparam logic [15:0] CW_QUICK_STOP  = 16'h0002;
	localparam logic [15:0] CW_SHUTDOWN    = 16'h0006;
	localparam logic [15:0] CW_SWITCH_ON   = 16'h0007;
	localparam logic [15:0] CW_ENABLE      = 16'h000F;
	localparam logic [15:0] CW_FAULT_RESET = 16'h0080;

	// status word reported in each state
	localparam logic [15:0] SW_INIT        = 16'h0000;
	localparam logic [15:0] SW_NO_FAULT    = 16'h0250;
	localparam logic [15:0] SW_READY       = 16'h0231;
	localparam logic [15:0] SW_WAIT_ON     = 16'h0233;
	localparam logic [15:0] SW_RUNNING     = 16'h0237;
	localparam logic [15:0] SW_QUICK_STOP  = 16'h0217;
	localparam logic [15:0] SW_STOP_FAULT  = 16'h021F;
	localparam logic [15:0] SW_FAULT       = 16'h0218;

	// quick-stop option codes
	localparam logic [15:0] QS_SERVO_OFF   = 16'h0000;
	localparam logic [15:0] QS_PROFILE     = 16'h0001;
	localparam logic [15:0] QS_QUICK       = 16'h0002;
	localparam logic [15:0] QS_PROFILE_HLD = 16'h0005;
	localparam logic [15:0] QS_QUICK_HLD   = 16'h0006;
	localparam logic [15:0] QS_RESET       = 16'h0002;

	// device object index of the option code
	localparam logic [15:0] QS_OPTION_IDX  = 16'h605A;

	// host register byte offsets
	localparam logic [7:0] CTRL_OFS        = 8'h00;
	localparam logic [7:0] STATUS_OFS      = 8'h04;
	localparam logic [7:0] OPTION_OFS      = 8'h08;
	localparam logic [7:0] RESULT_OFS      = 8'h0C;
	localparam int         RES_PENDING_BIT = 0;
	localparam int         RES_ERR_BIT     = 1;

	localparam logic [1:0] RESP_OKAY       = 2'h0;
	localparam logic [1:0] RESP_SLVERR     = 2'h2;

	function automatic logic [15:0] status_of(drive_state_type s);
		case (s)
			ST_INIT:       status_of = SW_INIT;
			ST_NO_FAULT:   status_of = SW_NO_FAULT;
			ST_READY:      status_of = SW_READY;
			ST_WAIT_ON:    status_of = SW_WAIT_ON;
			ST_RUNNING:    status_of = SW_RUNNING;
			ST_QUICK_STOP: status_of = SW_QUICK_STOP;
			ST_STOP_FAULT: status_of = SW_STOP_FAULT;
			ST_FAULT:      status_of = SW_FAULT;
			default:       status_of = SW_INIT;
		endcase
	endfunction

endpackage

// [drive_link_if.sv]
// link between the host controller and the drive state machine
`timescale 1ns/1ps
interface drive_link_if;
	logic [15:0] cw;
	logic        cw_valid;
	logic [15:0] status;
	logic        opt_wr;
	logic [15:0] opt_wdata;
	logic        opt_ack;
	logic        opt_err;
	logic [15:0] opt_rdata;

	modport device (
		input  cw,
		input  cw_valid,
		input  opt_wr,
		input  opt_wdata,
		output status,
		output opt_ack,
		output opt_err,
		output opt_rdata
	);

	modport host (
		output cw,
		output cw_valid,
		output opt_wr,
		output opt_wdata,
		input  status,
		input  opt_ack,
		input  opt_err,
		input  opt_rdata
	);
endinterface

// [quick_stop_option.sv]
// quick-stop option code register with value check
`timescale 1ns/1ps
module quick_stop_option (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        wr,
	input  wire logic [15:0] wdata,
	input  wire logic        allowed,
	output logic             ack,
	output logic             err,
	output logic [15:0]      code
);
	import drive_pkg::*;

	typedef struct packed {
		logic [15:0] code;
		logic        ack;
		logic        err;
	} opt_state_type;

	opt_state_type q, d;
	logic          legal;

	always_comb begin
		legal = (wdata == QS_SERVO_OFF) || (wdata == QS_PROFILE) ||
			(wdata == QS_QUICK) || (wdata == QS_PROFILE_HLD) ||
			(wdata == QS_QUICK_HLD);
		d = q;
		d.ack = wr;
		d.err = 1'b0;
		if (wr) begin
			if (legal && allowed) begin
				d.code = wdata;
			end else begin
				d.err = 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '{code: QS_RESET, ack: 1'b0, err: 1'b0};
		end else begin
			q <= d;
		end
	end

	assign ack  = q.ack;
	assign err  = q.err;
	assign code = q.code;
endmodule

// [drive_device.sv]
// drive-side device control state machine
// Overview of operation
// - power-up enters initialization, status 0x0000
// - init done to no-fault; failure to fault stop
// - no-fault plus 0x0006 goes to ready
// - ready plus 0x0007 goes to wait-on
// - wait-on plus 0x000F goes to running
// - running plus 0x0007 returns to wait-on
// - wait-on plus 0x0006 returns to ready
// - running plus 0x0006 goes to ready
// - ready plus 0x0000 returns to no-fault
// - wait-on plus 0x0000 returns to no-fault
// - running plus 0x0002 starts quick stop
// - options 0 to 2 leave stop to no-fault
// - any fault except in fault or fault stop: stop at fault
// - fault stop done moves to fault state
// - fault plus 0x80 returns to no-fault
// - options 5, 6 hold; 0x0F resumes running
// - option code 16-bit, values 0,1,2,5,6, default 2
// - option 0 removes power, stop method stop
// - options 1, 2 ramp profile or quick
// - options 5, 6 ramp then stay stopped
// - no parameter change during initialization
// - motor energized only while running
// - fault state inhibits all drive functions
`timescale 1ns/1ps
module drive_device (
	input  wire logic    aclk,
	input  wire logic    aresetn,
	drive_link_if.device link,
	input  wire logic    init_done,
	input  wire logic    init_fail,
	input  wire logic    fault_in,
	input  wire logic    stop_done,
	output logic         motor_on,
	output logic         mode_enable,
	output logic         servo_off_stop,
	output logic         ramp_profile,
	output logic         ramp_quick,
	output logic         drive_inhibit,
	output logic         param_allowed,
	output logic [2:0]   state_code
);
	import drive_pkg::*;

	typedef struct packed {
		drive_state_type st;
		logic            halted;
		logic [15:0]     status;
		logic            motor_on;
		logic            servo_off;
		logic            ramp_prof;
		logic            ramp_quick;
		logic            inhibit;
		logic            allowed;
	} dev_state_type;

	dev_state_type q, d;
	logic [15:0]   opt_code;
	logic          cmd;
	logic          opt_auto;
	logic          opt_hold;
	logic          ramping;

	quick_stop_option u_option (
		.aclk    (aclk),
		.aresetn (aresetn),
		.wr      (link.opt_wr),
		.wdata   (link.opt_wdata),
		.allowed (q.allowed),
		.ack     (link.opt_ack),
		.err     (link.opt_err),
		.code    (opt_code)
	);

	always_comb begin
		cmd      = link.cw_valid;
		opt_auto = (opt_code == QS_SERVO_OFF) || (opt_code == QS_PROFILE) ||
			(opt_code == QS_QUICK);
		opt_hold = (opt_code == QS_PROFILE_HLD) ||
			(opt_code == QS_QUICK_HLD);
		d = q;
		// outside fault and fault stop, a fault outranks any command arriving in the same cycle
		if (fault_in && q.st != ST_FAULT && q.st != ST_STOP_FAULT) begin
			d.st = ST_STOP_FAULT;
			d.halted = 1'b0;
		end else begin
			case (q.st)
				ST_INIT: begin
					if (init_fail) begin
						d.st = ST_STOP_FAULT;
					end else if (init_done) begin
						d.st = ST_NO_FAULT;
					end
				end
				ST_NO_FAULT: begin
					if (cmd && link.cw == CW_SHUTDOWN) begin
						d.st = ST_READY;
					end
				end
				ST_READY: begin
					if (cmd && link.cw == CW_SWITCH_ON) begin
						d.st = ST_WAIT_ON;
					end else if (cmd && link.cw == CW_DISABLE) begin
						d.st = ST_NO_FAULT;
					end
				end
				ST_WAIT_ON: begin
					if (cmd && link.cw == CW_ENABLE) begin
						d.st = ST_RUNNING;
					end else if (cmd && link.cw == CW_SHUTDOWN) begin
						d.st = ST_READY;
					end else if (cmd && link.cw == CW_DISABLE) begin
						d.st = ST_NO_FAULT;
					end
				end
				ST_RUNNING: begin
					if (cmd && link.cw == CW_SWITCH_ON) begin
						d.st = ST_WAIT_ON;
					end else if (cmd && link.cw == CW_SHUTDOWN) begin
						d.st = ST_READY;
					end else if (cmd && link.cw == CW_QUICK_STOP) begin
						d.st = ST_QUICK_STOP;
						d.halted = 1'b0;
					end
				end
				ST_QUICK_STOP: begin
					if (!q.halted && stop_done) begin
						if (opt_auto) begin
							d.st = ST_NO_FAULT;
						end else begin
							d.halted = 1'b1;
						end
					end else if (q.halted && opt_hold && cmd &&
						link.cw == CW_ENABLE) begin
						d.st = ST_RUNNING;
					end else if (q.halted && !opt_hold) begin
						// option rewritten to 0..2 while holding
						d.st = ST_NO_FAULT;
					end
				end
				ST_STOP_FAULT: begin
					if (stop_done) begin
						d.st = ST_FAULT;
					end
				end
				ST_FAULT: begin
					if (cmd && link.cw == CW_FAULT_RESET) begin
						d.st = ST_NO_FAULT;
					end
				end
				default: begin
					d.st = ST_INIT;
				end
			endcase
			// any other word falls through with no change
		end
		d.status = status_of(d.st);
		ramping = (d.st == ST_QUICK_STOP) && !d.halted;
		d.motor_on = (d.st == ST_RUNNING);
		d.allowed = (d.st != ST_INIT);
		// fault reaction is always servo off
		d.servo_off = (d.st == ST_STOP_FAULT);
		d.ramp_prof = 1'b0;
		d.ramp_quick = 1'b0;
		// option read live: a rewrite mid-stop changes ramp
		if (ramping) begin
			case (opt_code)
				QS_SERVO_OFF: begin
					d.servo_off = 1'b1;
				end
				QS_PROFILE, QS_PROFILE_HLD: begin
					d.ramp_prof = 1'b1;
				end
				QS_QUICK, QS_QUICK_HLD: begin
					d.ramp_quick = 1'b1;
				end
				default: begin
					// register refuses other codes
					d.servo_off = 1'b1;
				end
			endcase
		end
		d.inhibit = (d.st == ST_FAULT);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '{st: ST_INIT, halted: 1'b0, status: SW_INIT,
				motor_on: 1'b0, servo_off: 1'b0, ramp_prof: 1'b0,
				ramp_quick: 1'b0, inhibit: 1'b0,
				allowed: 1'b0};
		end else begin
			q <= d;
		end
	end

	assign link.status    = q.status;
	assign link.opt_rdata = opt_code;
	assign motor_on       = q.motor_on;
	assign mode_enable    = q.motor_on;
	assign servo_off_stop = q.servo_off;
	assign ramp_profile   = q.ramp_prof;
	assign ramp_quick     = q.ramp_quick;
	assign drive_inhibit  = q.inhibit;
	assign param_allowed  = q.allowed;
	assign state_code     = q.st;
endmodule

// [drive_host.sv]
// host controller end: AXI4-Lite registers driving the drive link
`timescale 1ns/1ps
module drive_host (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	drive_link_if.host       link,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);
	import drive_pkg::*;

	typedef struct packed {
		logic        aw_got;
		logic [7:0]  awaddr;
		logic        w_got;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic [15:0] cw;
		logic        cw_valid;
		logic        opt_wr;
		logic [15:0] opt_wdata;
		logic        pending;
		logic        opt_err;
	} host_state_type;

	host_state_type q, d;
	logic          aw_have, w_have;
	logic [7:0]    waddr, raddr;
	logic [31:0]   wd;
	logic [3:0]    ws;

	function automatic logic [15:0] merge(logic [15:0] old,
		logic [31:0] nw, logic [3:0] st);
		merge = {st[1] ? nw[15:8] : old[15:8], st[0] ? nw[7:0] : old[7:0]};
	endfunction

	always_comb begin
		d = q;
		d.cw_valid = 1'b0;
		d.opt_wr = 1'b0;
		aw_have = q.aw_got || s_axi_awvalid;
		w_have = q.w_got || s_axi_wvalid;
		waddr = q.aw_got ? q.awaddr : s_axi_awaddr;
		wd = q.w_got ? q.wdata : s_axi_wdata;
		ws = q.w_got ? q.wstrb : s_axi_wstrb;
		raddr = {s_axi_araddr[7:2], 2'b00};
		if (s_axi_awvalid && s_axi_awready) begin
			d.aw_got = 1'b1;
			d.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			d.w_got = 1'b1;
			d.wdata = s_axi_wdata;
			d.wstrb = s_axi_wstrb;
		end
		if (aw_have && w_have && !q.bvalid) begin
			d.aw_got = 1'b0;
			d.w_got = 1'b0;
			d.bvalid = 1'b1;
			d.bresp = RESP_OKAY;
			case ({waddr[7:2], 2'b00})
				CTRL_OFS: begin
					d.cw = merge(q.cw, wd, ws);
					d.cw_valid = 1'b1;
				end
				OPTION_OFS: begin
					// one option write in flight; later ones are refused
					if (!q.pending) begin
						d.opt_wdata = merge(link.opt_rdata, wd, ws);
						d.opt_wr = 1'b1;
						d.pending = 1'b1;
					end else begin
						d.bresp = RESP_SLVERR;
					end
				end
				STATUS_OFS, RESULT_OFS: begin
					d.bresp = RESP_OKAY;
				end
				default: begin
					d.bresp = RESP_SLVERR;
				end
			endcase
		end else if (q.bvalid && s_axi_bready) begin
			d.bvalid = 1'b0;
		end
		if (link.opt_ack) begin
			d.pending = 1'b0;
			d.opt_err = link.opt_err;
		end
		if (s_axi_arvalid && !q.rvalid) begin
			d.rvalid = 1'b1;
			d.rresp = RESP_OKAY;
			case (raddr)
				CTRL_OFS:   d.rdata = {16'h0000, q.cw};
				STATUS_OFS: d.rdata = {16'h0000, link.status};
				OPTION_OFS: d.rdata = {16'h0000, link.opt_rdata};
				RESULT_OFS: begin
					d.rdata = 32'h0000_0000;
					d.rdata[RES_PENDING_BIT] = q.pending;
					d.rdata[RES_ERR_BIT] = q.opt_err;
				end
				default: begin
					d.rdata = 32'h0000_0000;
					d.rresp = RESP_SLVERR;
				end
			endcase
		end else if (q.rvalid && s_axi_rready) begin
			d.rvalid = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign s_axi_awready = !q.aw_got && !q.bvalid;
	assign s_axi_wready  = !q.w_got && !q.bvalid;
	assign s_axi_bvalid  = q.bvalid;
	assign s_axi_bresp   = q.bresp;
	assign s_axi_arready = !q.rvalid;
	assign s_axi_rvalid  = q.rvalid;
	assign s_axi_rdata   = q.rdata;
	assign s_axi_rresp   = q.rresp;
	assign link.cw        = q.cw;
	assign link.cw_valid  = q.cw_valid;
	assign link.opt_wr    = q.opt_wr;
	assign link.opt_wdata = q.opt_wdata;
endmodule

// [drive_link_chk.sv]
// link assertions between the host and drive ends
`timescale 1ns/1ps
module drive_link_chk
	import drive_pkg::*;
(
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic [15:0] cw,
	input wire logic        cw_valid,
	input wire logic [15:0] status,
	input wire logic        opt_wr,
	input wire logic [15:0] opt_wdata,
	input wire logic        opt_ack,
	input wire logic        opt_err,
	input wire logic [15:0] opt_rdata
);
	logic known;
	logic good;
	assign known = cw inside {CW_DISABLE, CW_QUICK_STOP, CW_SHUTDOWN,
		CW_SWITCH_ON, CW_ENABLE, CW_FAULT_RESET};
	// writes during init are refused whatever the value
	assign good = status != SW_INIT && opt_wdata inside {QS_SERVO_OFF,
		QS_PROFILE, QS_QUICK, QS_PROFILE_HLD, QS_QUICK_HLD};
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_init;
		$rose(aresetn) |-> status == SW_INIT;
	endproperty
	a_init: assert property (p_init) else $error("init");
	property p_ready;
		cw_valid && cw == CW_SHUTDOWN && status == SW_NO_FAULT |=>
			status == SW_READY;
	endproperty
	a_ready: assert property (p_ready) else $error("ready");
	property p_wait;
		cw_valid && cw == CW_SWITCH_ON && status == SW_READY |=>
			status == SW_WAIT_ON;
	endproperty
	a_wait: assert property (p_wait) else $error("wait");
	property p_qstop;
		cw_valid && cw == CW_QUICK_STOP && status == SW_RUNNING |=>
			status == SW_QUICK_STOP;
	endproperty
	a_qstop: assert property (p_qstop) else $error("qstop");
	property p_freset;
		cw_valid && cw == CW_FAULT_RESET && status == SW_FAULT |=>
			status == SW_NO_FAULT;
	endproperty
	a_freset: assert property (p_freset) else $error("freset");
	property p_ignore;
		cw_valid && !known |=> $stable(status);
	endproperty
	a_ignore: assert property (p_ignore) else $error("ignore");
	property p_opt_bad;
		opt_wr && !good |=> opt_ack && opt_err && $stable(opt_rdata)
			##1 !opt_ack;
	endproperty
	a_opt_bad: assert property (p_opt_bad) else $error("opt");
	property p_opt_ok;
		opt_wr && good |=> opt_ack && !opt_err
			##1 opt_rdata == $past(opt_wdata, 2);
	endproperty
	a_opt_ok: assert property (p_opt_ok) else $error("opt ok");
	c_run: cover property (status == SW_RUNNING);
	c_held: cover property (status == SW_QUICK_STOP && cw == CW_ENABLE);
	c_fault: cover property (status == SW_FAULT);
endmodule

// [tb_drive_profile_state_machine.sv]
// bench for the drive state machine with its host end
`timescale 1ns/1ps
module tb_drive_profile_state_machine;
	import drive_pkg::*;
	logic        aclk = 1'h0, aresetn = 1'h0;
	logic        init_done = 1'h0, init_fail = 1'h0;
	logic        fault_in = 1'h0, stop_done = 1'h0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
	logic        s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
	logic        s_axi_rready = 1'h0, s_axi_awready, s_axi_wready;
	logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
	logic        motor_on, mode_enable, servo_off_stop, ramp_profile;
	logic        ramp_quick, drive_inhibit, param_allowed;
	logic [2:0]  state_code;
	int          err_count = 0, n_compared = 0, cyc = 0, m = 0, opt = 2;
	bit          held = 1'h0;
	logic [15:0] sw_tab [8] = '{SW_INIT, SW_NO_FAULT, SW_READY, SW_WAIT_ON,
		SW_RUNNING, SW_QUICK_STOP, SW_STOP_FAULT, SW_FAULT};
	logic [15:0] cw_tab [6] = '{CW_DISABLE, CW_QUICK_STOP, CW_SHUTDOWN,
		CW_SWITCH_ON, CW_ENABLE, CW_FAULT_RESET};
	logic [15:0] op_tab [5] = '{QS_SERVO_OFF, QS_PROFILE, QS_QUICK,
		QS_PROFILE_HLD, QS_QUICK_HLD};

	drive_link_if link ();
	drive_link_chk i_drive_link_chk (.aclk(aclk), .aresetn(aresetn),
		.cw(link.cw), .cw_valid(link.cw_valid), .status(link.status),
		.opt_wr(link.opt_wr), .opt_wdata(link.opt_wdata),
		.opt_ack(link.opt_ack), .opt_err(link.opt_err),
		.opt_rdata(link.opt_rdata));
	drive_device i_drive_device (.aclk(aclk), .aresetn(aresetn),
		.link(link), .init_done(init_done), .init_fail(init_fail),
		.fault_in(fault_in), .stop_done(stop_done), .motor_on(motor_on),
		.mode_enable(mode_enable), .servo_off_stop(servo_off_stop),
		.ramp_profile(ramp_profile), .ramp_quick(ramp_quick),
		.drive_inhibit(drive_inhibit), .param_allowed(param_allowed),
		.state_code(state_code));
	drive_host i_drive_host (.aclk(aclk), .aresetn(aresetn), .link(link),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready));

	always #50 aclk = ~aclk;

	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_count++;
			finish_test();
		end
	end

	task automatic finish_test();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic cmp(input logic [31:0] got, exp, input string s);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH %0t %s %h %h", $time, s, got, exp);
		end
	endtask

	task automatic axi_wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {16'h0000, d};
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'h0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'h0;
		end while (!s_axi_bvalid);
		rs = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask

	task automatic axi_rd(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'h0;
		end while (!s_axi_rvalid);
		rd = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask

	function automatic int nxt(int s, logic [15:0] c);
		case (s)
			1: return c == CW_SHUTDOWN ? 2 : 1;
			2: return c == CW_SWITCH_ON ? 3 : c == CW_DISABLE ? 1 : 2;
			3: return c == CW_ENABLE ? 4 : c == CW_SHUTDOWN ? 2 :
				c == CW_DISABLE ? 1 : 3;
			4: return c == CW_SWITCH_ON ? 3 : c == CW_SHUTDOWN ? 2 :
				c == CW_QUICK_STOP ? 5 : 4;
			5: return held && c == CW_ENABLE ? 4 : 5;
			7: return c == CW_FAULT_RESET ? 1 : 7;
			default: return s;
		endcase
	endfunction

	task automatic chk();
		#1;
		cmp(link.status, sw_tab[m], "st");
		cmp(state_code, m, "code");
		cmp({motor_on, mode_enable}, {2{m == 4}}, "mot");
		cmp(drive_inhibit, m == 7, "inh");
		cmp(param_allowed, m != 0, "par");
	endtask

	task automatic cmd(input logic [15:0] c);
		axi_wr(CTRL_OFS, c);
		m = nxt(m, c);
		held = held && m == 5;
		chk();
	endtask

	// one extra edge so a registered input stage is also covered
	task automatic ev(input bit f);
		@(posedge aclk);
		fault_in <= f;
		stop_done <= !f;
		@(posedge aclk);
		fault_in <= 1'h0;
		stop_done <= 1'h0;
		@(posedge aclk);
		if (f)
			m = m == 7 ? 7 : 6;
		else if (m == 5) begin
			held = opt > 2;
			m = held ? 5 : 1;
		end else if (m == 6)
			m = 7;
		chk();
	endtask

	task automatic setopt(input logic [15:0] v);
		bit ok;
		ok = v inside {[0:2], 5, 6} && m != 0;
		axi_wr(OPTION_OFS, v);
		cmp(rs, RESP_OKAY, "obresp");
		repeat (2) @(posedge aclk);
		if (ok)
			opt = v;
		axi_rd(RESULT_OFS);
		cmp(rd[RES_ERR_BIT], !ok, "oerr");
		cmp(rd[RES_PENDING_BIT], 1'h0, "pend");
		axi_rd(OPTION_OFS);
		cmp(rd, opt, "opt");
	endtask

	task automatic to_run();
		while (m != 4)
			if (m == 6 || m == 5 && !held)
				ev(1'h0);
			else
				cmd(m == 1 ? CW_SHUTDOWN : m == 2 ? CW_SWITCH_ON :
					m == 7 ? CW_FAULT_RESET : CW_ENABLE);
	endtask

	initial begin
		void'($urandom(32'hA8C9));
		repeat (3) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		chk();
		setopt(QS_PROFILE_HLD);
		axi_rd(8'h40);
		cmp(rs, RESP_SLVERR, "unmap");
		axi_rd(STATUS_OFS);
		cmp(rd, 32'h0, "strd");
		init_done <= 1'h1;
		m = 1;
		repeat (2) @(posedge aclk);
		chk();
		to_run();
		cmd(CW_SHUTDOWN);
		cmd(CW_SWITCH_ON);
		cmd(CW_SHUTDOWN);
		cmd(CW_DISABLE);
		to_run();
		cmd(CW_SWITCH_ON);
		cmd(CW_DISABLE);
		setopt(op_tab[0]);
		foreach (op_tab[i]) begin
			setopt(16'($urandom) | 16'h0008);
			repeat (8)
				cmd($urandom_range(0, 7) > 5 ? 16'($urandom) :
					cw_tab[$urandom_range(0, 5)]);
			to_run();
			cmd(CW_QUICK_STOP);
			cmp(servo_off_stop, opt == 0, "off");
			cmp(ramp_profile, opt == 1 || opt == 5, "prf");
			cmp(ramp_quick, opt == 2 || opt == 6, "qck");
			cmd(CW_ENABLE);
			ev(1'h0);
			cmp({servo_off_stop, ramp_profile, ramp_quick}, 3'h0,
				"halt");
			to_run();
			ev(1'h1);
			cmp(servo_off_stop, 1'h1, "fstp");
			cmd(CW_FAULT_RESET);
			ev(1'h0);
			setopt(op_tab[(i + 1) % 5]);
			cmd(CW_FAULT_RESET);
		end
		@(posedge aclk);
		aresetn <= 1'h0;
		init_done <= 1'h0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'h1;
		m = 0;
		opt = 2;
		@(posedge aclk);
		chk();
		@(posedge aclk);
		init_fail <= 1'h1;
		m = 6;
		repeat (2) @(posedge aclk);
		chk();
		axi_rd(OPTION_OFS);
		cmp(rd, 32'h2, "ordf");
		finish_test();
	end
endmodule
